// *** hw/spm_low_timer.sv ***
// Purpose: counts consecutive cycles of run and flags when the limit is reached
// Assumes: run comes from logic on the same clock
// Notes:   done is high from the limit-th run cycle while run stays high
`timescale 1ns/100ps
module spm_low_timer #(
  parameter int unsigned LIMIT = 16
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  spm_tmr_if.timer        tmr
);
  localparam int CW = $clog2(LIMIT + 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  // ****************************************************************
  // saturating run counter
  // ****************************************************************
  // saturation keeps done steady if the owner is slow to drop run
  always_comb begin
    next_count = count;
    if (!tmr.run) begin
      next_count = '0;
    end else if (count != CW'(LIMIT - 1)) begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // counts begin at zero, so limit minus one marks the limit-th cycle
  assign tmr.done = tmr.run && (count == CW'(LIMIT - 1));
endmodule

// *** hw/spm_pin_mode.sv ***
// Purpose: pin function and mode selection of a motion sensor front end
// Assumes: pins arrive unsynchronised; user side signals share the clock
// Notes:   pin outputs lag the state by one cycle, all registered
//
// Functional notes
// - bus strap high gives SPI, low I2C
// - clock pin feeds SPI or I2C clock
// - boot strap caught once after reset
// - motion boot: pin two open-drain boot done
// - default boot: pin two interrupt or trigger
// - select pin wakes hibernate only in default boot
// - default boot: pin one is interrupt output
// - device pulses line low on motion
// - motion line level selects detection threshold
// - hibernate floats serial pins and pin two
// - hibernate select pin input only default boot
// - hibernate pin one input only motion boot
// - interrupt pins configurable, revert to push-pull
// - three-wire SPI makes data pin bidirectional
// - address pin is I2C address LSB or MISO
// - boot strap low default, high motion mode
`timescale 1ns/100ps
module spm_pin_mode #(
  parameter int unsigned HIB_CYCLES   = spm_pkg::HIB_ENTRY_CYCLES,
  parameter int unsigned PULSE_CYCLES = spm_pkg::MOTION_PULSE_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       bus_select_strap,
  input  wire logic       boot_select_strap,
  input  wire logic       sclk_pin,
  input  wire logic       cs_n_pin,
  input  wire logic       addr_lsb_pin_in,
  output logic            addr_lsb_pin_out,
  output logic            addr_lsb_pin_oe,
  input  wire logic       data_pin_in,
  output logic            data_pin_out,
  output logic            data_pin_oe,
  input  wire logic       irq_pin_one_in,
  output logic            irq_pin_one_out,
  output logic            irq_pin_one_oe,
  input  wire logic       irq_pin_two_in,
  output logic            irq_pin_two_out,
  output logic            irq_pin_two_oe,
  input  wire logic       spi_three_wire,
  input  wire logic       spi_miso_data,
  input  wire logic       spi_miso_oe,
  input  wire logic       ser_data_out,
  input  wire logic       ser_data_oe,
  input  wire logic       irq_one_level,
  input  wire logic       irq_two_level,
  input  wire logic       irq_cfg_wr,
  input  wire logic [3:0] irq_cfg_data,
  input  wire logic       boot_done,
  input  wire logic       motion_detected,
  input  wire logic       hib_request,
  output logic            spi_mode,
  output logic            boot_motion,
  output logic            motion_thr_sel,
  output logic            hibernate,
  output logic            spi_sclk,
  output logic            i2c_scl,
  output logic            spi_select,
  output logic            i2c_addr_lsb,
  output logic            ser_data_in,
  output logic            measure_trigger_in,
  output logic            irq_one_input,
  output logic            motion_enable,
  output logic            cs_in_en,
  output logic            pin_one_in_en,
  output logic [3:0]      irq_cfg
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [spm_pkg::PIN_N-1:0] pin_raw;
  logic [spm_pkg::PIN_N-1:0] sync1;
  logic [spm_pkg::PIN_N-1:0] sync2;

  assign pin_raw = {irq_pin_two_in, irq_pin_one_in, data_pin_in, addr_lsb_pin_in,
                    cs_n_pin, sclk_pin, boot_select_strap, bus_select_strap};

  // two flops per pin; only the second is read
  for (genvar g = 0; g < spm_pkg::PIN_N; g++) begin : g_sync
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        sync1[g] <= 1'b0;
        sync2[g] <= 1'b0;
      end else begin
        sync1[g] <= pin_raw[g];
        sync2[g] <= sync1[g];
      end
    end
  end

  logic s_cs_n;
  logic s_line;
  assign s_cs_n = sync2[spm_pkg::PIN_CS];
  assign s_line = sync2[spm_pkg::PIN_ONE];

  // ****************************************************************
  // timers for host low time and motion pulse
  // ****************************************************************
  spm_tmr_if hib_tmr ();
  spm_tmr_if pulse_tmr ();

  spm_low_timer #(.LIMIT(HIB_CYCLES)) u_hib_tmr (
    .clock   (clock),
    .sys_rst (sys_rst),
    .tmr     (hib_tmr)
  );

  spm_low_timer #(.LIMIT(PULSE_CYCLES)) u_pulse_tmr (
    .clock   (clock),
    .sys_rst (sys_rst),
    .tmr     (pulse_tmr)
  );

  // ****************************************************************
  // mode state
  // ****************************************************************
  spm_pkg::spm_state_e state;
  spm_pkg::spm_state_e next_state;
  logic [1:0]          fill_cnt;
  logic [1:0]          next_fill_cnt;
  logic                next_boot_motion;
  logic                next_spi_mode;
  logic                next_thr_sel;
  logic [3:0]          next_irq_cfg;

  // own pulse pulls the line low, so host timing only runs in ST_RUN
  assign hib_tmr.run   = (state == spm_pkg::ST_RUN) && boot_motion && !s_line;
  assign pulse_tmr.run = (state == spm_pkg::ST_PULSE);

  always_comb begin
    next_state       = state;
    next_fill_cnt    = fill_cnt;
    next_boot_motion = boot_motion;
    next_thr_sel     = motion_thr_sel;
    next_irq_cfg     = irq_cfg;
    next_spi_mode    = sync2[spm_pkg::PIN_BUS];
    unique case (state)
      spm_pkg::ST_BOOT: begin
        if (fill_cnt == spm_pkg::SYNC_FILL_CYCLES) begin
          next_boot_motion = sync2[spm_pkg::PIN_BOOT];
          next_thr_sel     = s_line;
          next_state       = spm_pkg::ST_RUN;
        end else begin
          next_fill_cnt = fill_cnt + 1'b1;
        end
      end
      spm_pkg::ST_RUN: begin
        if (boot_motion && motion_detected) begin
          next_state = spm_pkg::ST_PULSE;
        end else if (boot_motion && hib_tmr.done) begin
          next_state = spm_pkg::ST_HIB;
        end else if (!boot_motion && hib_request) begin
          next_state = spm_pkg::ST_HIB;
        end
      end
      spm_pkg::ST_PULSE: begin
        if (pulse_tmr.done) begin
          next_state = spm_pkg::ST_RUN;
        end
      end
      spm_pkg::ST_HIB: begin
        // motion boot wakes when the host lets the line rise
        if ((boot_motion && s_line) || (!boot_motion && !s_cs_n)) begin
          next_state   = spm_pkg::ST_RUN;
          next_irq_cfg = spm_pkg::IRQ_CFG_RESET;
        end
      end
    endcase
    // writes while asleep are dropped, the wake would discard them anyway
    if (irq_cfg_wr && (state == spm_pkg::ST_RUN || state == spm_pkg::ST_PULSE)) begin
      next_irq_cfg = irq_cfg_data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state          <= spm_pkg::ST_BOOT;
      fill_cnt       <= 2'h0;
      boot_motion    <= 1'b0;
      spi_mode       <= 1'b0;
      motion_thr_sel <= 1'b0;
      irq_cfg        <= spm_pkg::IRQ_CFG_RESET;
    end else begin
      state          <= next_state;
      fill_cnt       <= next_fill_cnt;
      boot_motion    <= next_boot_motion;
      spi_mode       <= next_spi_mode;
      motion_thr_sel <= next_thr_sel;
      irq_cfg        <= next_irq_cfg;
    end
  end

  // ****************************************************************
  // pin functions
  // ****************************************************************
  // returns {out, oe} for an interrupt level under a configuration
  function automatic logic [1:0] irq_drive(input logic [1:0] cfg, input logic level);
    logic [1:0] r;
    r = 2'h0;
    unique case (cfg)
      spm_pkg::IRQ_PUSH_PULL:   r = {level, 1'b1};
      spm_pkg::IRQ_OPEN_DRAIN:  r = {1'b0, !level};
      spm_pkg::IRQ_OPEN_SOURCE: r = {1'b1, level};
      spm_pkg::IRQ_INPUT:       r = 2'h0;
    endcase
    return r;
  endfunction

  logic [1:0] drv_one;
  logic [1:0] drv_two;
  logic       asleep;
  logic       live;
  logic [1:0] next_one;
  logic [1:0] next_two;
  logic [1:0] next_addr;
  logic [1:0] next_data;
  logic [7:0] next_flags;
  logic [4:0] next_ins;

  assign drv_one = irq_drive(irq_cfg[1:0], irq_one_level);
  assign drv_two = irq_drive(irq_cfg[3:2], irq_two_level);
  assign asleep  = (state == spm_pkg::ST_HIB);
  assign live    = (state == spm_pkg::ST_RUN) || (state == spm_pkg::ST_PULSE);

  // all drivers off while booting and while asleep
  always_comb begin
    next_one  = 2'h0;
    next_two  = 2'h0;
    next_addr = 2'h0;
    next_data = 2'h0;
    if (live) begin
      if (boot_motion) begin
        next_one = {1'b0, state == spm_pkg::ST_PULSE};
        next_two = {1'b0, !boot_done};
      end else begin
        next_one = drv_one;
        next_two = drv_two;
      end
      if (spi_mode) begin
        next_addr = {spi_miso_data, spi_miso_oe && !spi_three_wire && !s_cs_n};
        next_data = {ser_data_out, ser_data_oe && spi_three_wire};
      end else begin
        next_data = {1'b0, ser_data_oe && !ser_data_out};
      end
    end
    // {hibernate, spi_sclk, i2c_scl, spi_select, i2c_addr_lsb, trigger, irq in, enable}
    next_flags = {asleep,
                  !asleep && spi_mode && sync2[spm_pkg::PIN_SCLK],
                  asleep || spi_mode || sync2[spm_pkg::PIN_SCLK],
                  live && spi_mode && !s_cs_n,
                  !spi_mode && sync2[spm_pkg::PIN_ADDR],
                  live && !boot_motion && irq_cfg[3:2] == spm_pkg::IRQ_INPUT
                    && sync2[spm_pkg::PIN_TWO],
                  live && !boot_motion && irq_cfg[1:0] == spm_pkg::IRQ_INPUT && s_line,
                  (state == spm_pkg::ST_RUN) && boot_motion && s_line};
    // {ser_data_in, cs_in_en, pin_one_in_en, spare}
    next_ins   = {sync2[spm_pkg::PIN_DATA], !asleep || !boot_motion,
                  !asleep || boot_motion, 2'h0};
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      {irq_pin_one_out, irq_pin_one_oe} <= 2'h0;
      {irq_pin_two_out, irq_pin_two_oe} <= 2'h0;
      {addr_lsb_pin_out, addr_lsb_pin_oe} <= 2'h0;
      {data_pin_out, data_pin_oe} <= 2'h0;
      {hibernate, spi_sclk, i2c_scl, spi_select, i2c_addr_lsb,
       measure_trigger_in, irq_one_input, motion_enable} <= 8'h20;
      {ser_data_in, cs_in_en, pin_one_in_en} <= 3'h3;
    end else begin
      {irq_pin_one_out, irq_pin_one_oe} <= next_one;
      {irq_pin_two_out, irq_pin_two_oe} <= next_two;
      {addr_lsb_pin_out, addr_lsb_pin_oe} <= next_addr;
      {data_pin_out, data_pin_oe} <= next_data;
      {hibernate, spi_sclk, i2c_scl, spi_select, i2c_addr_lsb,
       measure_trigger_in, irq_one_input, motion_enable} <= next_flags;
      {ser_data_in, cs_in_en, pin_one_in_en} <= next_ins[4:2];
    end
  end

  // ****************************************************************
  // assertions and their helper counters
  // ****************************************************************
  int unsigned pulse_len;
  int unsigned low_len;
  logic [1:0]  age;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pulse_len <= 0;
      low_len   <= 0;
      age       <= 2'h0;
    end else begin
      pulse_len <= irq_pin_one_oe ? pulse_len + 1 : 0;
      low_len   <= s_line ? 0 : low_len + 1;
      age       <= (age == 2'h3) ? age : age + 2'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence seq_leave_hib;
    state == spm_pkg::ST_HIB ##1 state != spm_pkg::ST_HIB;
  endsequence

  sequence seq_boot_done;
    state == spm_pkg::ST_BOOT ##1 state == spm_pkg::ST_RUN;
  endsequence

  a_bus_strap: assert property (age == 2'h3 |-> spi_mode == $past(bus_select_strap, 3))
    else $error("bus mode does not follow strap");
  a_sclk_route: assert property ($past(!asleep && spi_mode) |-> spi_sclk == $past(sync2[2]))
    else $error("serial clock not routed");
  a_boot_held: assert property (state != spm_pkg::ST_BOOT |=> $stable(boot_motion))
    else $error("boot selection changed");
  a_boot_done_od: assert property ($past(boot_motion && live) |->
      !irq_pin_two_out && irq_pin_two_oe == !$past(boot_done))
    else $error("boot done pin not open-drain");
  a_trig_input: assert property ($past(live && !boot_motion && irq_cfg[3:2] == 2'h3)
      |-> !irq_pin_two_oe)
    else $error("trigger pin driven");
  a_cs_wake: assert property (state == spm_pkg::ST_HIB && !boot_motion && !s_cs_n
      |=> state == spm_pkg::ST_RUN)
    else $error("select pin did not wake");
  a_one_irq: assert property ($past(live && !boot_motion && irq_cfg[1:0] == 2'h0) |->
      irq_pin_one_oe && irq_pin_one_out == $past(irq_one_level))
    else $error("pin one not push-pull interrupt");
  a_hib_entry: assert property ($rose(state == spm_pkg::ST_HIB) && boot_motion
      |-> low_len >= HIB_CYCLES)
    else $error("hibernate entered too early");
  a_pulse_width: assert property ($fell(irq_pin_one_oe) && boot_motion
      |-> pulse_len == PULSE_CYCLES && !irq_pin_one_out)
    else $error("motion pulse width wrong");
  a_thr_capture: assert property (seq_boot_done |-> motion_thr_sel == $past(s_line))
    else $error("threshold select not caught");
  a_hib_float: assert property (hibernate |-> !irq_pin_two_oe && !data_pin_oe
      && !addr_lsb_pin_oe)
    else $error("pin driven in hibernate");
  a_hib_inputs: assert property (hibernate |-> cs_in_en == !boot_motion
      && pin_one_in_en == boot_motion)
    else $error("hibernate input enables wrong");
  a_irq_revert: assert property (seq_leave_hib |-> irq_cfg == spm_pkg::IRQ_CFG_RESET)
    else $error("interrupt config not reverted");
  a_three_wire: assert property ($past(live && spi_mode && spi_three_wire) |->
      !addr_lsb_pin_oe && data_pin_oe == $past(ser_data_oe))
    else $error("three-wire data pin wrong");
  a_addr_lsb: assert property ($past(!spi_mode) |-> i2c_addr_lsb == $past(sync2[4]))
    else $error("address bit not passed");

endmodule

// *** hw/spm_pkg.sv ***
// Purpose: shared constants and types of the sensor pin mode control block
// Assumes: device clock of 40 MHz
// Notes:   times are kept in microseconds, cycle counts derive from them
package spm_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ               = 40;
  // hib_entry_low_time: the host must hold the motion line low longer than this
  localparam int unsigned HIB_ENTRY_LOW_TIME_US = 1000;
  // motion_pulse_width: length of the low pulse signalling detected motion
  localparam int unsigned MOTION_PULSE_WIDTH_US = 1000;
  // strictly longer than the entry time, so one cycle beyond the figure
  localparam int unsigned HIB_ENTRY_CYCLES      = HIB_ENTRY_LOW_TIME_US * CLK_MHZ + 1;
  localparam int unsigned MOTION_PULSE_CYCLES   = MOTION_PULSE_WIDTH_US * CLK_MHZ;
  // cycles for the pin synchronisers to fill before the boot strap is caught
  localparam logic [1:0]  SYNC_FILL_CYCLES      = 2'h2;

  // ****************************************************************
  // synchronised pin positions
  // ****************************************************************
  localparam int PIN_BUS  = 0;
  localparam int PIN_BOOT = 1;
  localparam int PIN_SCLK = 2;
  localparam int PIN_CS   = 3;
  localparam int PIN_ADDR = 4;
  localparam int PIN_DATA = 5;
  localparam int PIN_ONE  = 6;
  localparam int PIN_TWO  = 7;
  localparam int PIN_N    = 8;

  // ****************************************************************
  // interrupt pin configuration, two bits per pin, pin one in [1:0]
  // ****************************************************************
  localparam logic [1:0] IRQ_PUSH_PULL   = 2'h0;
  localparam logic [1:0] IRQ_OPEN_DRAIN  = 2'h1;
  localparam logic [1:0] IRQ_OPEN_SOURCE = 2'h2;
  localparam logic [1:0] IRQ_INPUT       = 2'h3;
  localparam logic [3:0] IRQ_CFG_RESET   = 4'h0;

  typedef enum logic [1:0] {
    ST_BOOT  = 2'b00,
    ST_RUN   = 2'b01,
    ST_PULSE = 2'b10,
    ST_HIB   = 2'b11
  } spm_state_e;

endpackage

// *** hw/spm_tmr_if.sv ***
// Purpose: run and done pair between the mode control and a timer
// Assumes: both ends on the device clock
// Notes:   done is combinational from the timer count
`timescale 1ns/100ps
interface spm_tmr_if;
  logic run;
  logic done;
  modport owner (output run, input done);
  modport timer (input run, output done);
endinterface

// *** tb/spm_host_model.sv ***
// Purpose: host side of the two multifunction pins, with their pull-ups
// Assumes: both lines carry an external pull-up resistor
// Notes:   a released line floats to the pull-up level, never keeps a stale value
`timescale 1ns/100ps
module spm_host_model (
  input  wire logic irq_pin_one_out,
  input  wire logic irq_pin_one_oe,
  input  wire logic irq_pin_two_out,
  input  wire logic irq_pin_two_oe,
  input  wire logic host_one_low,
  input  wire logic host_two_low,
  output logic      pin_one_level,
  output logic      pin_two_level
);
  // ****************************************************************
  // wire resolution
  // ****************************************************************
  // host only ever pulls low; high comes from the resistor
  assign pin_one_level = (irq_pin_one_oe ? irq_pin_one_out : 1'b1) & ~host_one_low;
  // open-drain done line, or a trigger the host pulls low
  assign pin_two_level = (irq_pin_two_oe ? irq_pin_two_out : 1'b1) & ~host_two_low;
endmodule

// *** tb/tb_top.sv ***
// Purpose: self-checking bench of the sensor pin mode control block
// Assumes: short timer parameters, host pins resolved by the host model
// Notes:   inputs change 2 ns after the rising edge, outputs are read there too
`timescale 1ns/100ps
module tb_top;
  logic       clock, sys_rst, bus_s, boot_s, sclk_pin, cs_n_pin, addr_in, data_in;
  logic       three_w, miso_d, miso_oe, sd_out, sd_oe, lvl_one, lvl_two, cfg_wr;
  logic [3:0] cfg_d, irq_cfg;
  logic       boot_done, motion_det, hib_req, one_low, two_low, p1, p2;
  logic       a_out, a_oe, d_out, d_oe, o1_out, o1_oe, o2_out, o2_oe;
  logic       spi_mode, boot_motion, thr_sel, hibernate, spi_sclk, i2c_scl, spi_select;
  logic       i2c_lsb, ser_in, trig, irq_one_in, mot_en, cs_in_en, p1_in_en;
  int         num_errors, num_checks;
  localparam int HIB = 10;
  localparam int PULSE = 8;

  spm_pin_mode #(.HIB_CYCLES(HIB), .PULSE_CYCLES(PULSE)) u_dut (
    .clock(clock), .sys_rst(sys_rst), .bus_select_strap(bus_s),
    .boot_select_strap(boot_s), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
    .addr_lsb_pin_in(addr_in), .addr_lsb_pin_out(a_out), .addr_lsb_pin_oe(a_oe),
    .data_pin_in(data_in), .data_pin_out(d_out), .data_pin_oe(d_oe),
    .irq_pin_one_in(p1), .irq_pin_one_out(o1_out), .irq_pin_one_oe(o1_oe),
    .irq_pin_two_in(p2), .irq_pin_two_out(o2_out), .irq_pin_two_oe(o2_oe),
    .spi_three_wire(three_w), .spi_miso_data(miso_d), .spi_miso_oe(miso_oe),
    .ser_data_out(sd_out), .ser_data_oe(sd_oe), .irq_one_level(lvl_one),
    .irq_two_level(lvl_two), .irq_cfg_wr(cfg_wr), .irq_cfg_data(cfg_d),
    .boot_done(boot_done), .motion_detected(motion_det), .hib_request(hib_req),
    .spi_mode(spi_mode), .boot_motion(boot_motion), .motion_thr_sel(thr_sel),
    .hibernate(hibernate), .spi_sclk(spi_sclk), .i2c_scl(i2c_scl),
    .spi_select(spi_select), .i2c_addr_lsb(i2c_lsb), .ser_data_in(ser_in),
    .measure_trigger_in(trig), .irq_one_input(irq_one_in), .motion_enable(mot_en),
    .cs_in_en(cs_in_en), .pin_one_in_en(p1_in_en), .irq_cfg(irq_cfg));

  spm_host_model u_host (
    .irq_pin_one_out(o1_out), .irq_pin_one_oe(o1_oe), .irq_pin_two_out(o2_out),
    .irq_pin_two_oe(o2_oe), .host_one_low(one_low), .host_two_low(two_low),
    .pin_one_level(p1), .pin_two_level(p2));

  // ****************************************************************
  // clock and helpers
  // ****************************************************************
  // 40 MHz
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // straps settle well before release, since the boot level is caught after it
  task automatic do_reset(input logic bus, input logic boot);
    bus_s = bus;
    boot_s = boot;
    sys_rst = 1'b1;
    tick(12);
    sys_rst = 1'b0;
    tick(6);
  endtask

  // bounded wait; running out ends the run as a mismatch
  task automatic wait_hib(input logic exp);
    for (int i = 0; i < 60; i++) begin
      if (hibernate === exp)
        return;
      tick(1);
    end
    num_errors++;
    $display("BAD hibernate wait expected %h", exp);
    wrap_up();
  endtask

  task automatic cfg_write(input logic [3:0] d);
    cfg_wr = 1'b1;
    cfg_d = d;
    tick(1);
    cfg_wr = 1'b0;
    tick(4);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_spi_pins;
    do_reset(1'b1, 1'b0);
    chk("spi_mode", 4'h1, spi_mode);
    chk("boot_motion", 4'h0, boot_motion);
    sclk_pin = 1'b1;
    boot_s = 1'b1;
    cs_n_pin = 1'b0;
    miso_oe = 1'b1;
    miso_d = 1'b1;
    data_in = 1'b1;
    tick(5);
    chk("ser data in", 4'h1, ser_in);
    chk("spi_sclk", 4'h1, spi_sclk);
    chk("boot held", 4'h0, boot_motion);
    chk("spi_select", 4'h1, spi_select);
    chk("miso oe", 4'h1, a_oe);
    chk("miso out", 4'h1, a_out);
    three_w = 1'b1;
    sd_oe = 1'b1;
    tick(5);
    chk("3w data oe", 4'h1, d_oe);
    chk("3w data out", 4'h0, d_out);
    chk("3w addr oe", 4'h0, a_oe);
    // select released high so the default hibernate test is not woken at once
    {boot_s, cs_n_pin, miso_oe, three_w, sd_oe} = 5'h08;
    tick(5);
  endtask

  // every drive code at level low: expected {out, oe} per code
  task automatic t_irq_cfg;
    logic [1:0] exp [4];
    exp = '{2'b01, 2'b01, 2'b10, 2'b00};
    for (int k = 0; k < 4; k++) begin
      cfg_write(4'(k));
      chk("irq_cfg", 4'(k), irq_cfg);
      chk("pin one oe", {3'h0, exp[k][0]}, o1_oe);
      if (k < 3)
        chk("pin one out", {3'h0, exp[k][1]}, o1_out);
      if (k == 3)
        chk("pin one input", 4'h1, irq_one_in);
    end
    cfg_write(4'hC);
    chk("pin two oe", 4'h0, o2_oe);
    chk("trigger high", 4'h1, trig);
    two_low = 1'b1;
    tick(5);
    chk("trigger low", 4'h0, trig);
    two_low = 1'b0;
    tick(5);
  endtask

  task automatic t_default_hib;
    hib_req = 1'b1;
    tick(1);
    hib_req = 1'b0;
    wait_hib(1'b1);
    tick(2);
    chk("hib pin two oe", 4'h0, o2_oe);
    chk("hib data oe", 4'h0, d_oe);
    chk("hib addr oe", 4'h0, a_oe);
    chk("hib cs input", 4'h1, cs_in_en);
    chk("hib pin one in", 4'h0, p1_in_en);
    cs_n_pin = 1'b0;
    wait_hib(1'b0);
    tick(2);
    chk("cfg reverted", 4'h0, irq_cfg);
    chk("push-pull oe", 4'h1, o1_oe);
    cs_n_pin = 1'b1;
  endtask

  task automatic t_motion_boot;
    int n;
    boot_done = 1'b0;
    do_reset(1'b0, 1'b1);
    chk("i2c mode", 4'h0, spi_mode);
    chk("motion boot", 4'h1, boot_motion);
    chk("threshold", 4'h1, thr_sel);
    chk("motion en", 4'h1, mot_en);
    chk("done low oe", 4'h1, o2_oe);
    chk("done low out", 4'h0, o2_out);
    sclk_pin = 1'b0;
    addr_in = 1'b1;
    boot_done = 1'b1;
    tick(5);
    chk("i2c_scl", 4'h0, i2c_scl);
    chk("i2c lsb", 4'h1, i2c_lsb);
    chk("done released", 4'h0, o2_oe);
    motion_det = 1'b1;
    tick(1);
    motion_det = 1'b0;
    n = 0;
    for (int i = 0; i < 10 && o1_oe !== 1'b1; i++)
      tick(1);
    chk("pulse out", 4'h0, o1_out);
    while (o1_oe === 1'b1 && n < 40) begin
      n++;
      tick(1);
    end
    chk("pulse width", 4'(PULSE), 4'(n));
  endtask

  task automatic t_motion_hib;
    // let the line sit high after the pulse so the low timer starts from zero
    tick(4);
    one_low = 1'b1;
    tick(HIB - 2);
    one_low = 1'b0;
    tick(6);
    chk("short low", 4'h0, hibernate);
    one_low = 1'b1;
    wait_hib(1'b1);
    chk("one input", 4'h1, p1_in_en);
    chk("cs floats", 4'h0, cs_in_en);
    // line stays low, so only the select pin could wake the device here
    cs_n_pin = 1'b0;
    tick(7);
    chk("no cs wake", 4'h1, hibernate);
    chk("hib two oe", 4'h0, o2_oe);
    cs_n_pin = 1'b1;
    one_low = 1'b0;
    wait_hib(1'b0);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    num_errors = 0;
    num_checks = 0;
    {sys_rst, bus_s, boot_s, sclk_pin, cs_n_pin, addr_in, data_in} = 7'h48;
    {three_w, miso_d, miso_oe, sd_out, sd_oe, lvl_one, lvl_two, cfg_wr} = 8'h00;
    {cfg_d, boot_done, motion_det, hib_req, one_low, two_low} = 9'h000;
    t_spi_pins();
    t_irq_cfg();
    t_default_hib();
    t_motion_boot();
    t_motion_hib();
    wrap_up();
  end
endmodule
